// ===== logic/mubs_slave.sv
// module: muxed address/data utility bus slave
// Summary of operation
// - falling latch strobe captures address
// - drive read data only during reads
// - write data taken at write end
// - fetch and store strobes act only with select asserted; latch strobe captures address regardless of select
// - select may stay asserted permanently
// - write sampled when store or select rises
// - async active-low reset clears control logic
`timescale 1ns/1ps
`default_nettype none
module mubs_slave #(
  parameter int unsigned DATA_W = mubs_pkg::MUBS_DATA_W
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [DATA_W-1:0] bus_in,
  output logic [DATA_W-1:0] bus_out,
  output logic bus_oe_b,
  input wire logic latch_strobe,
  input wire logic device_select_b,
  input wire logic fetch_strobe_b,
  input wire logic store_strobe_b,
  output logic [DATA_W-1:0] reg_addr,
  output logic reg_rd_pulse,
  input wire logic [DATA_W-1:0] reg_rd_data,
  output logic reg_wr_pulse,
  output logic [DATA_W-1:0] reg_wr_data
);
  // reset release through two flops
  logic rst_meta;
  logic rst_sync_b;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync_b <= rst_meta;
    end
  end

  // strobes: {latch, select_b, fetch_b, store_b}
  logic [3:0] strb_s;
  mubs_sync #(.WIDTH(4), .RST_VAL(4'h7)) u_sync (
    .clk(clk),
    .rst_b(rst_sync_b),
    .async_in({latch_strobe, device_select_b, fetch_strobe_b,
      store_strobe_b}),
    .sync_out(strb_s)
  );
  // data lines pass a further stage so they lag the strobes
  logic [DATA_W-1:0] bus_d1;
  logic [DATA_W-1:0] bus_d2;
  logic [DATA_W-1:0] bus_d3;
  logic [3:0] strb_q;
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      bus_d1 <= '0;
      bus_d2 <= '0;
      bus_d3 <= '0;
      strb_q <= 4'h7;
    end else begin
      bus_d1 <= bus_in;
      bus_d2 <= bus_d1;
      bus_d3 <= bus_d2;
      strb_q <= strb_s;
    end
  end

  wire latch_fall = strb_q[3] & ~strb_s[3];
  wire sel = ~strb_s[2];
  wire rd_act = sel & ~strb_s[1] & strb_s[0] & ~strb_s[3];
  wire wr_act = sel & ~strb_s[0] & strb_s[1] & ~strb_s[3];

  mubs_pkg::mubs_state_e state;
  mubs_pkg::mubs_state_e next_state;
  logic wr_done;
  always_comb begin
    next_state = state;
    wr_done = 1'b0;
    case (state)
      mubs_pkg::MUBS_IDLE: begin
        if (rd_act) begin
          next_state = mubs_pkg::MUBS_READ;
        end else if (wr_act) begin
          next_state = mubs_pkg::MUBS_WRITE;
        end
      end
      mubs_pkg::MUBS_READ: begin
        if (!rd_act) begin
          next_state = mubs_pkg::MUBS_IDLE;
        end
      end
      mubs_pkg::MUBS_WRITE: begin
        if (!wr_act) begin
          next_state = mubs_pkg::MUBS_IDLE;
          wr_done = 1'b1;
        end
      end
      default: next_state = mubs_pkg::MUBS_IDLE;
    endcase
  end

  wire rd_start = (state == mubs_pkg::MUBS_IDLE) & rd_act;
  wire drive = (next_state == mubs_pkg::MUBS_READ);

  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      state <= mubs_pkg::MUBS_IDLE;
      reg_addr <= mubs_pkg::MUBS_ADDR_RST;
      reg_rd_pulse <= 1'b0;
      reg_wr_pulse <= 1'b0;
      reg_wr_data <= mubs_pkg::MUBS_DATA_RST;
      bus_out <= mubs_pkg::MUBS_DATA_RST;
      bus_oe_b <= 1'b1;
    end else begin
      state <= next_state;
      reg_rd_pulse <= rd_start;
      reg_wr_pulse <= wr_done;
      bus_oe_b <= ~drive;
      if (latch_fall) begin
        reg_addr <= bus_d3;
      end
      if (wr_done) begin
        reg_wr_data <= bus_d3;
      end
      if (drive) begin
        bus_out <= reg_rd_data;
      end
    end
  end
endmodule // mubs_slave
`default_nettype wire

// ===== logic/mubs_pkg.sv
// package: utility bus slave constants and states
package mubs_pkg;
  localparam int unsigned MUBS_DATA_W = 8;
  localparam int unsigned MUBS_SYNC_STAGES = 2;
  localparam logic [7:0] MUBS_ADDR_RST = 8'h00;
  localparam logic [7:0] MUBS_DATA_RST = 8'h00;
  typedef enum logic [1:0] {
    MUBS_IDLE = 2'b00,
    MUBS_READ = 2'b01,
    MUBS_WRITE = 2'b10
  } mubs_state_e;
endpackage

// ===== logic/mubs_sync.sv
// module: per-bit two-flop synchroniser
`timescale 1ns/1ps
`default_nettype none
module mubs_sync #(
  parameter int unsigned WIDTH = 4,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic meta;
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          meta <= RST_VAL[i];
          sync_out[i] <= RST_VAL[i];
        end else begin
          meta <= async_in[i];
          sync_out[i] <= meta;
        end
      end
    end
  endgenerate
endmodule // mubs_sync
`default_nettype wire

// ===== bench/mubs_monitor.sv
// checker for the utility bus slave ports
`timescale 1ns/1ps
`default_nettype none
module mubs_chk (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic bus_oe_b,
  input wire logic latch_strobe,
  input wire logic device_select_b,
  input wire logic fetch_strobe_b,
  input wire logic store_strobe_b,
  input wire logic [7:0] reg_addr,
  input wire logic reg_rd_pulse,
  input wire logic reg_wr_pulse
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  wire go = !device_select_b && !latch_strobe;
  property p_rd; $fell(fetch_strobe_b) && go |-> ##[2:4] !bus_oe_b; endproperty
  a_rd: assert property (p_rd) else $error("no drive");
  property p_hz; fetch_strobe_b [*5] |-> bus_oe_b; endproperty
  a_hz: assert property (p_hz) else $error("stray drive");
  property p_wr; $rose(store_strobe_b) && $past(go) |-> ##[2:4] reg_wr_pulse;
  endproperty
  a_wr: assert property (p_wr) else $error("no write");
  property p_cs; device_select_b [*5] |-> !reg_wr_pulse && !reg_rd_pulse;
  endproperty
  a_cs: assert property (p_cs) else $error("unselected");
  property p_ad; $changed(reg_addr) |-> !latch_strobe; endproperty
  a_ad: assert property (p_ad) else $error("addr");
  property p_pl; $fell(bus_oe_b) |-> reg_rd_pulse ##1 !reg_rd_pulse; endproperty
  a_pl: assert property (p_pl) else $error("pulse");
endmodule // mubs_chk
bind mubs_slave mubs_chk i_chk (.clk(clk), .rst_b(rst_b), .bus_oe_b(bus_oe_b),
  .latch_strobe(latch_strobe), .device_select_b(device_select_b),
  .fetch_strobe_b(fetch_strobe_b), .store_strobe_b(store_strobe_b),
  .reg_addr(reg_addr), .reg_rd_pulse(reg_rd_pulse), .reg_wr_pulse(reg_wr_pulse));
`default_nettype wire

// ===== bench/mubs_host.sv
// host model for the muxed utility bus
`timescale 1ns/1ps
`default_nettype none
module mubs_host (
  input wire logic clk,
  input wire logic [7:0] bus,
  output logic [7:0] h_d,
  output logic [3:0] pins,
  output logic [7:0] q
);
  // pins: latch, select_b, fetch_b, store_b
  initial pins = 4'h7;
  initial h_d = 8'h00;
  task acc(input logic w, input logic [7:0] a, d, input logic s, k);
    @(negedge clk) pins[3] = 1'b1;
    h_d = a;
    repeat (4) @(negedge clk);
    pins[3] = 1'b0;
    repeat (4) @(negedge clk);
    h_d = w ? d : ~h_d;
    pins[2:0] = {s, w, !w};
    repeat (6) @(negedge clk);
    q = bus;
    pins[2:0] = {k, 2'b11};
    repeat (6) @(negedge clk);
  endtask
endmodule // mubs_host
`default_nettype wire

// ===== bench/tb.sv
// testbench for the utility bus slave
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  int mismatches = 0;
  int cmp_count = 0;
  logic [7:0] nw = 8'h00;
  logic [7:0] nr = 8'h00;
  wire logic [7:0] h_d, dout, addr, wdat, bus, q;
  wire logic [3:0] p;
  wire logic oe_b, wp, rp;
  assign bus = oe_b ? h_d : dout;
  always #2 clk = ~clk;
  always @(posedge clk) if (wp) nw <= nw + 8'h01;
  always @(posedge clk) if (rp) nr <= nr + 8'h01;
  mubs_host i_host (.clk(clk), .bus(bus), .h_d(h_d), .pins(p), .q(q));
  mubs_slave i_dut (.clk(clk), .rst_b(rst_b), .bus_in(bus), .bus_out(dout),
    .bus_oe_b(oe_b), .latch_strobe(p[3]), .device_select_b(p[2]),
    .fetch_strobe_b(p[1]), .store_strobe_b(p[0]), .reg_addr(addr),
    .reg_rd_pulse(rp), .reg_rd_data(addr ^ 8'h3c), .reg_wr_pulse(wp),
    .reg_wr_data(wdat));
  task chk(input logic [7:0] s, e);
    cmp_count++;
    if (s !== e) begin
      mismatches++;
      $display("unexpected at %0t: %h vs %h", $time, s, e);
    end
  endtask
  task close_out;
    if (mismatches == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task t_wr;
    i_host.acc(1'b1, 8'h5a, 8'ha3, 1'b0, 1'b1);
    chk(addr, 8'h5a);
    chk(wdat, 8'ha3);
    chk(nw, 8'h01);
  endtask
  task t_unsel;
    i_host.acc(1'b1, 8'h33, 8'h0f, 1'b1, 1'b0);
    chk(nw, 8'h01);
    chk(nr, 8'h00);
  endtask
  task t_rd;
    i_host.acc(1'b0, 8'h81, 8'h00, 1'b0, 1'b0);
    chk(q, 8'hbd);
    chk(nr, 8'h01);
    chk({7'h00, oe_b}, 8'h01);
  endtask
  initial begin
    repeat (16) @(negedge clk);
    rst_b = 1'b1;
    repeat (6) @(negedge clk);
    t_wr;
    t_unsel;
    t_rd;
    close_out;
  end
endmodule // tb
`default_nettype wire
